// ---- hw/ssc_consts.svh ----
/*
  offsets, field positions, opcodes, reset values and geometry of the
  storage security command block.
  assumes: included by bare name, before the modules that use it.
*/
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SSC_OFF_DATA   4'h0
`define SSC_OFF_FEAT   4'h1
`define SSC_OFF_CNT    4'h2
`define SSC_OFF_LO     4'h3
`define SSC_OFF_MID    4'h4
`define SSC_OFF_HI     4'h5
`define SSC_OFF_DH     4'h6
`define SSC_OFF_CMD    4'h7
`define SSC_OFF_ERR    4'h8
`define SSC_OFF_IRQ    4'h9
`define SSC_OFF_MASK   4'ha
`define SSC_OFF_SEC    4'hb
// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define SSC_OP_SETPW   8'hf1
`define SSC_OP_UNLOCK  8'hf2
`define SSC_OP_ERASE   8'hf4
`define SSC_OP_FREEZE  8'hf5
`define SSC_OP_SEEK    4'h7
// ------------------------------------------------------------
// fields and values
// ------------------------------------------------------------
`define SSC_TRIES_INIT 3'h5
`define SSC_WORD_LAST  8'hff
`define SSC_PW_FIRST   8'h01
`define SSC_PW_LAST    8'h10
`define SSC_CTL_SEL    0
`define SSC_CTL_LVL    8
`define SSC_DH_LBA     6
`define SSC_ERR_ABRT   8'h04
`define SSC_ERR_IDNF   8'h10
`define SSC_ST_BSY     7
`define SSC_ST_DRQ     3
`define SSC_ST_ERR     0
`define SSC_IRQ_DONE   0
`define SSC_IRQ_DRQ    1
`define SSC_IRQ_LOCK   2
// ------------------------------------------------------------
// geometry for the seek range check
// ------------------------------------------------------------
`define SSC_LBA_LIMIT  28'h000f_6180
`define SSC_CYLS       16'h03e8
`define SSC_HEADS      5'h10
`define SSC_SPT        8'h3f
`endif

// ---- hw/ssc_pkg.sv ----
/*
  types of the storage security command block.
  assumes: compiled before every module of the block.
*/
package ssc_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_data = 2'b01,
    st_exec = 2'b11
  } ssc_state_type;

  typedef struct packed {
    logic [7:0] feat;
    logic [7:0] cnt;
    logic [7:0] lo;
    logic [7:0] mid;
    logic [7:0] hi;
    logic [7:0] dh;
  } ssc_taskfile_type;

  typedef struct packed {
    logic       locked;
    logic       level_max;
    logic       armed;
    logic       frozen;
    logic [2:0] tries;
  } ssc_secstate_type;
endpackage : ssc_pkg

// ---- hw/ssc_range_chk.sv ----
/*
  range check of a seek address, chs or lba.
  assumes: task-file fields are stable while ok is sampled.
*/
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_range_chk (
  // task-file address
  input  wire ssc_pkg::ssc_taskfile_type tf,
  // result
  output logic                           ok
);
  wire        lba_mode = tf.dh[`SSC_DH_LBA];
  wire [27:0] lba      = {tf.dh[3:0], tf.hi, tf.mid, tf.lo};
  wire [15:0] cyl      = {tf.hi, tf.mid};
  wire        chs_ok   = cyl < `SSC_CYLS && {1'b0, tf.dh[3:0]} < `SSC_HEADS
                         && tf.lo != 8'h00 && tf.lo <= `SSC_SPT;

  assign ok = lba_mode ? lba < `SSC_LBA_LIMIT : chs_ok;
endmodule : ssc_range_chk

// ---- hw/ssc_sector_rx.sv ----
/*
  takes in one 256-word data sector: control word and password.
  assumes: wr_en only while the owner waits for sector data.
*/
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_sector_rx (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ce,
  // word stream
  input  wire logic         start,
  input  wire logic         wr_en,
  input  wire logic [15:0]  wdata,
  // sector contents
  output logic      [15:0]  ctrl_q,
  output logic      [255:0] pw_q,
  output logic              last
);
  logic [7:0] idx_q;
  wire        in_pw = idx_q >= `SSC_PW_FIRST && idx_q <= `SSC_PW_LAST;
  wire  [7:0] slot  = idx_q - `SSC_PW_FIRST;

  assign last = wr_en && idx_q == `SSC_WORD_LAST;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx_q  <= 8'h00;
      ctrl_q <= 16'h0000;
      pw_q   <= '0;
    end else if (ce && start) begin
      idx_q <= 8'h00;
    end else if (ce && wr_en) begin
      idx_q <= idx_q + 8'h01;
      if (idx_q == 8'h00) ctrl_q <= wdata;
      if (in_pw) pw_q[{slot[3:0], 4'h0} +: 16] <= wdata;
    end
  end
endmodule : ssc_sector_rx

// ---- hw/ssc_top.sv ----
/*
  storage security command interpreter: set password, unlock, freeze,
  seek, with task-file registers, sector data port and interrupt.
  assumes: one clock, registers reached by a strobed port, data words
  written to the data offset only while status shows a data request.
*/
// What this block does
// - set password takes exactly one sector first
// - word zero bit0 target, bit8 level
// - password is words one to sixteen
// - user high: store, arm lock, both unlock
// - user max: store, arm, master cannot unlock
// - master target: store master only
// - unlock opcode f2 takes one sector
// - master select at high: compare master
// - master select at max: reject, no compare
// - user select compares user password
// - mismatch aborts; while locked it decrements attempt counter
// - counter starts at five, counts locked mismatches
// - counter zero aborts unlock, erase until reset
// - seek 7x only range checks address
// - lba from head, cyl high, low, sector
// - opcode f1 is set password
// - after freeze, reject lock-changing commands
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_top (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  // hardware reset pulse, keeps passwords
  input  wire logic        hw_reset,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data_q,
  // interrupt
  output logic             irq_q
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ssc_pkg::ssc_state_type    state_q, state_d;
  ssc_pkg::ssc_taskfile_type tf_q;
  ssc_pkg::ssc_secstate_type sec_q;
  logic [7:0]   cmd_q;
  logic [7:0]   err_q;
  logic         err_flag_q;
  logic [2:0]   sts_q;
  logic [2:0]   mask_q;
  logic [255:0] user_pw_q;
  logic [255:0] master_pw_q;
  logic [15:0]  ctrl;
  logic [255:0] pw;
  logic         last;
  logic         seek_ok;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire w_cmd  = wr_en && addr == `SSC_OFF_CMD && state_q == ssc_pkg::st_idle;
  wire w_data = wr_en && addr == `SSC_OFF_DATA && state_q == ssc_pkg::st_data;
  wire w_mask = wr_en && addr == `SSC_OFF_MASK;
  wire w_tf   = wr_en && addr >= `SSC_OFF_FEAT && addr <= `SSC_OFF_DH;
  wire r_irq  = rd_en && addr == `SSC_OFF_IRQ;
  wire [7:0] op = wr_data[7:0];

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  // set password opcode
  wire is_setpw  = op == `SSC_OP_SETPW;
  wire is_unlock = op == `SSC_OP_UNLOCK;
  wire is_erase  = op == `SSC_OP_ERASE;
  wire is_freeze = op == `SSC_OP_FREEZE;
  wire is_seek   = op[7:4] == `SSC_OP_SEEK;
  wire tries_out = sec_q.tries == 3'h0;
  wire frz_rej   = sec_q.frozen && (is_setpw || is_unlock || is_erase);
  wire lock_rej  = tries_out && (is_unlock || is_erase);
  // erase unit is not supported beyond its lockout, so it aborts too
  wire bad_op    = !(is_setpw || is_unlock || is_freeze || is_seek);
  wire go_data   = w_cmd && (is_setpw || is_unlock) && !frz_rej && !lock_rej;
  wire cmd_abort = w_cmd && (frz_rej || lock_rej || bad_op);
  wire seek_bad  = w_cmd && is_seek && !seek_ok;

  // ------------------------------------------------------------
  // sector execution
  // ------------------------------------------------------------
  wire ex       = state_q == ssc_pkg::st_exec;
  wire ex_setpw = ex && cmd_q == `SSC_OP_SETPW;
  wire ex_unl   = ex && cmd_q == `SSC_OP_UNLOCK;
  wire sel_mst  = ctrl[`SSC_CTL_SEL];
  wire lvl_max  = ctrl[`SSC_CTL_LVL];
  logic u_match;
  logic m_match;
  assign u_match = pw == user_pw_q;
  assign m_match = pw == master_pw_q;
  // master at max level rejected uncompared
  wire unl_rej  = ex_unl && sel_mst && sec_q.level_max;
  wire unl_hit  = sel_mst ? m_match : u_match;
  wire unl_ok   = ex_unl && !unl_rej && unl_hit;
  wire unl_miss = ex_unl && !unl_rej && !unl_hit;
  wire dec      = unl_miss && sec_q.locked && !tries_out;
  wire ex_abort = unl_rej || unl_miss;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ssc_pkg::st_idle: begin
        if (go_data) state_d = ssc_pkg::st_data;
      end
      ssc_pkg::st_data: begin
        if (last) state_d = ssc_pkg::st_exec;
      end
      ssc_pkg::st_exec: begin
        state_d = ssc_pkg::st_idle;
      end
      default: begin
        state_d = ssc_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) state_q <= ssc_pkg::st_idle;
    else if (ce) state_q <= state_d;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cmd_q <= 8'h00;
    else if (ce && w_cmd) cmd_q <= op;
  end

  ssc_sector_rx u_rx (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .start   (go_data),
    .wr_en   (w_data),
    .wdata   (wr_data),
    .ctrl_q  (ctrl),
    .pw_q    (pw),
    .last    (last)
  );

  ssc_range_chk u_chk (
    .tf (tf_q),
    .ok (seek_ok)
  );

  // ------------------------------------------------------------
  // task file
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tf_q <= '0;
    end else if (ce && w_cmd && is_freeze) begin
      tf_q.cnt <= 8'h00;
    end else if (ce && w_tf) begin
      tf_q[8 * (`SSC_OFF_DH - addr) +: 8] <= wr_data[7:0];
    end
  end

  // ------------------------------------------------------------
  // passwords and security state
  // ------------------------------------------------------------
  // passwords live until power-on reset; a hardware reset keeps them
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      user_pw_q   <= '0;
      master_pw_q <= '0;
    end else if (ce && ex_setpw) begin
      if (!sel_mst) user_pw_q <= pw;
      else master_pw_q <= pw;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sec_q <= '{1'b0, 1'b0, 1'b0, 1'b0, `SSC_TRIES_INIT};
    end else if (ce && hw_reset) begin
      sec_q.locked <= sec_q.armed;
      sec_q.tries  <= `SSC_TRIES_INIT;
      sec_q.frozen <= 1'b0;
    end else if (ce) begin
      if (ex_setpw && !sel_mst) begin
        sec_q.armed     <= 1'b1;
        sec_q.level_max <= lvl_max;
      end
      if (w_cmd && is_freeze) sec_q.frozen <= 1'b1;
      if (unl_ok) sec_q.locked <= 1'b0;
      if (dec) sec_q.tries <= sec_q.tries - 3'h1;
    end
  end

  // ------------------------------------------------------------
  // error and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_q      <= 8'h00;
      err_flag_q <= 1'b0;
    end else if (ce && (w_cmd || ex)) begin
      err_q      <= (cmd_abort || ex_abort) ? `SSC_ERR_ABRT :
                    seek_bad ? `SSC_ERR_IDNF : 8'h00;
      err_flag_q <= cmd_abort || ex_abort || seek_bad;
    end
  end

  wire       done_ev = (w_cmd && !go_data) || ex;
  wire       lock_ev = dec && sec_q.tries == 3'h1;
  wire [2:0] ev      = {lock_ev, go_data, done_ev};
  // an event in the clearing read's cycle stays set
  wire [2:0] sts_d   = ev | (r_irq ? 3'h0 : sts_q);
  // a new mask shows on the interrupt pin at the same edge as in the register
  wire [2:0] mask_d  = w_mask ? wr_data[2:0] : mask_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sts_q  <= 3'h0;
      mask_q <= 3'h0;
      irq_q  <= 1'b0;
    end else if (ce) begin
      sts_q  <= sts_d;
      irq_q  <= |(sts_d & mask_d);
      mask_q <= mask_d;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  wire [7:0] status = {state_q == ssc_pkg::st_exec, 3'h0,
                       state_q == ssc_pkg::st_data, 2'h0, err_flag_q};
  wire [15:0] rd_mux =
    addr == `SSC_OFF_CMD  ? {8'h00, status} :
    addr == `SSC_OFF_ERR  ? {8'h00, err_q} :
    addr == `SSC_OFF_IRQ  ? {13'h0000, sts_q} :
    addr == `SSC_OFF_MASK ? {13'h0000, mask_q} :
    addr == `SSC_OFF_SEC  ? {9'h000, sec_q} :
    (addr >= `SSC_OFF_FEAT && addr <= `SSC_OFF_DH) ?
      {8'h00, tf_q[8 * (`SSC_OFF_DH - addr) +: 8]} : 16'h0000;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rd_data_q <= 16'h0000;
    else if (ce) rd_data_q <= rd_en ? rd_mux : 16'h0000;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_SECTOR_WHOLE: assert property (
    ce && state_q == ssc_pkg::st_data && !last |=> state_q == ssc_pkg::st_data)
    else $error("left data phase before the last word");
  AST_LOCKOUT_ABORT: assert property (
    ce && w_cmd && is_unlock && tries_out |=>
      state_q == ssc_pkg::st_idle && err_q == `SSC_ERR_ABRT)
    else $error("unlock not aborted at lockout");
  AST_FROZEN_REJECT: assert property (
    ce && w_cmd && is_setpw && sec_q.frozen |=>
      state_q == ssc_pkg::st_idle && err_flag_q)
    else $error("set password accepted while frozen");
  AST_DECREMENT: assert property (
    ce && !hw_reset && ex_unl && !unl_rej && !unl_hit && sec_q.locked && !tries_out
      |=> sec_q.tries == $past(sec_q.tries) - 3'h1 && err_q == `SSC_ERR_ABRT)
    else $error("locked mismatch did not cost one attempt");
  AST_KEEP_TRIES: assert property (
    ce && !hw_reset && ex_unl && (!sec_q.locked || unl_hit) |=> $stable(sec_q.tries))
    else $error("attempt counter moved on match or when unlocked");
  AST_MAX_MASTER: assert property (
    ce && !hw_reset && ex_unl && sel_mst && sec_q.level_max
      |=> $stable(sec_q.locked) && $stable(sec_q.tries) && err_flag_q)
    else $error("master unlock at maximum level not rejected");
  AST_MASTER_SET: assert property (
    ce && !hw_reset && ex_setpw && sel_mst
      |=> $stable(sec_q.level_max) && $stable(sec_q.armed) && master_pw_q == $past(pw))
    else $error("master set touched lock state");
  AST_SEEK_NOP: assert property (
    ce && w_cmd && is_seek |=> state_q == ssc_pkg::st_idle && $stable(user_pw_q)
      && err_flag_q == !$past(seek_ok))
    else $error("seek did more than a range check");
  AST_IRQ_LEVEL: assert property (
    ce |=> irq_q == |(sts_q & mask_q))
    else $error("interrupt does not follow masked status");
  AST_SETPW_DATA: assert property (
    ce && w_cmd && is_setpw && !sec_q.frozen |=> state_q == ssc_pkg::st_data)
    else $error("set password did not ask for its sector");
  AST_UNLOCK_DATA: assert property (
    ce && w_cmd && is_unlock && !sec_q.frozen && !tries_out |=>
      state_q == ssc_pkg::st_data && sts_q[`SSC_IRQ_DRQ])
    else $error("unlock did not ask for its sector");
  AST_USER_SET: assert property (
    ce && !hw_reset && ex_setpw && !sel_mst |=> user_pw_q == $past(pw)
      && sec_q.armed && sec_q.level_max == $past(lvl_max))
    else $error("user set did not store and arm");
  AST_MASTER_HIGH: assert property (
    ce && !hw_reset && ex_unl && sel_mst && !sec_q.level_max && m_match
      |=> !sec_q.locked && !err_flag_q)
    else $error("master password refused at high level");
  AST_USER_MATCH: assert property (
    ce && !hw_reset && ex_unl && !sel_mst && u_match |=> !sec_q.locked && !err_flag_q)
    else $error("matching user password refused");
  AST_MISS_ABORT: assert property (
    ce && ex_unl && !unl_rej && !unl_hit |=> err_flag_q && err_q == `SSC_ERR_ABRT)
    else $error("failed compare not aborted");
  AST_TRIES_FLOOR: assert property (
    ce && !hw_reset && tries_out |=> tries_out)
    else $error("attempt counter left zero without reset");
  AST_HW_RESET: assert property (
    ce && hw_reset |=> sec_q.tries == `SSC_TRIES_INIT && !sec_q.frozen)
    else $error("hardware reset did not restore attempts");

  COV_UNLOCK_OK: cover property (ce && unl_ok && sec_q.locked);
  COV_LOCKOUT: cover property (ce && lock_ev);
  COV_SETPW_USER: cover property (ce && ex_setpw && !sel_mst);
  COV_SEEK_BAD: cover property (ce && seek_bad);
endmodule : ssc_top

// ---- tb/ssc_host_model.sv ----
/*
  host controller model: register strobes, command bytes, data sectors.
  assumes: one shared clock; the device never stalls the register port.
*/
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_host_model (
  // clock
  input  wire logic        clk_sys,
  // register port
  output logic      [3:0]  addr,
  output logic      [15:0] wr_data,
  output logic             wr_en,
  output logic             rd_en,
  input  wire logic [15:0] rd_data_q
);
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  initial begin
    addr    = 4'h0;
    wr_data = 16'h0000;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
  end

  // idle data shows the inverse, so a stale value is never mistaken
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    d = rd_data_q;
  endtask : rd

  // ------------------------------------------------------------
  // data sector
  // ------------------------------------------------------------
  // exactly one sector
  task automatic sector(input logic [15:0] ctl, input logic [255:0] pw);
    for (int i = 0; i < 256; i++) begin
      if (i == 0) begin
        wr(`SSC_OFF_DATA, ctl);
      end else if (i < 17) begin
        wr(`SSC_OFF_DATA, pw[16*i-1 -: 16]);
      end else begin
        wr(`SSC_OFF_DATA, 16'hffff);
      end
    end
  endtask : sector
endmodule : ssc_host_model

// ---- tb/tb_top.sv ----
/*
  self-checking bench of the security command block, one task a scenario.
  assumes: ssc_top with its package and header; host model drives the port.
*/
`timescale 1ns/1ps
`include "ssc_consts.svh"
`define SSC_CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk_sys;
  logic        nrst;
  logic        ce;
  logic        hw_reset;
  logic [3:0]  addr;
  logic [15:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rd_data_q;
  logic        irq_q;
  int          errors;
  int          compares;
  localparam logic [255:0] PW_U = {8{32'h1234_abcd}};
  // differs only in the top byte, so a partial compare would pass it
  localparam logic [255:0] PW_X = PW_U ^ {8'h01, 248'h0};

  always #20 clk_sys = ~clk_sys;

  ssc_top uut (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .hw_reset(hw_reset), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
    .irq_q(irq_q)
  );
  ssc_host_model host (
    .clk_sys(clk_sys), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_q(rd_data_q)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    host.rd(a, d);
    `SSC_CHK(d & m, e)
  endtask : rdchk

  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    logic [15:0] d;
    for (int i = 0; i < 16; i++) begin
      host.rd(`SSC_OFF_CMD, d);
      if ((d[7:0] & m) === e) return;
    end
    errors++;
    $display("[FAIL] %0t status wait ran out", $time);
    close_out();
  endtask : poll

  task automatic cmd(input logic [7:0] op, input logic sect, input logic [15:0] ctl,
                     input logic [255:0] pw, input logic [7:0] err);
    host.wr(`SSC_OFF_CMD, {8'h00, op});
    if (sect) begin
      poll(8'h08, 8'h08);
      host.sector(ctl, pw);
    end
    poll(8'h88, 8'h00);
    rdchk(`SSC_OFF_ERR, 16'h00ff, {8'h00, err});
  endtask : cmd

  task automatic hwrst();
    @(posedge clk_sys);
    hw_reset <= 1'b1;
    @(posedge clk_sys);
    hw_reset <= 1'b0;
  endtask : hwrst

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdchk(`SSC_OFF_SEC, 16'hffff, 16'h0005); // tries start five
    rdchk(4'hc, 16'hffff, 16'h0000);
    $display("reset values done");
  endtask : t_reset

  task automatic t_seek();
    // dh, hi, mid, lo, expected error
    logic [39:0] tbl [5] = '{40'h40_0f_61_7f_00, 40'h40_0f_61_80_10,
                             40'h41_00_00_00_10, 40'h00_00_00_00_10, 40'h00_00_00_01_00};
    for (int i = 0; i < 5; i++) begin
      host.wr(`SSC_OFF_DH, {8'h00, tbl[i][39:32]});
      host.wr(`SSC_OFF_HI, {8'h00, tbl[i][31:24]});
      host.wr(`SSC_OFF_MID, {8'h00, tbl[i][23:16]});
      host.wr(`SSC_OFF_LO, {8'h00, tbl[i][15:8]});
      cmd((i == 4) ? 8'h7f : 8'h70 + 8'(i), 1'b0, 16'h0, 256'h0, tbl[i][7:0]);
    end
    rdchk(`SSC_OFF_SEC, 16'hffff, 16'h0005); // no side effect
    $display("seek done");
  endtask : t_seek

  task automatic t_user_high();
    cmd(`SSC_OP_SETPW, 1'b1, 16'hfefe, PW_U, 8'h00);
    rdchk(`SSC_OFF_SEC, 16'h0070, 16'h0010); // armed, high level
    hwrst();
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0045); // locked after reset
    cmd(`SSC_OP_UNLOCK, 1'b1, 16'h0000, PW_X, 8'h04);
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0044); // one decrement
    cmd(`SSC_OP_UNLOCK, 1'b1, 16'h0001, 256'h0, 8'h00); // master unlocks
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0004); // unchanged on match
    cmd(`SSC_OP_UNLOCK, 1'b1, 16'h0000, PW_X, 8'h04); // unlocked mismatch
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0004); // no decrement
    $display("user high done");
  endtask : t_user_high

  task automatic t_user_max();
    cmd(`SSC_OP_SETPW, 1'b1, 16'h0100, PW_U, 8'h00);
    hwrst();
    rdchk(`SSC_OFF_SEC, 16'h0067, 16'h0065); // locked at max level
    cmd(`SSC_OP_UNLOCK, 1'b1, 16'h0001, 256'h0, 8'h04); // master refused
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0045); // no compare, no decrement
    cmd(`SSC_OP_UNLOCK, 1'b1, 16'h0000, PW_U, 8'h00); // user compare
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0005); // unlocked
    cmd(`SSC_OP_SETPW, 1'b1, 16'h0001, PW_X, 8'h00); // master set
    rdchk(`SSC_OFF_SEC, 16'h0070, 16'h0030); // level and arming kept
    $display("user max done");
  endtask : t_user_max

  task automatic t_lockout();
    logic [15:0] d;
    hwrst();
    host.rd(`SSC_OFF_IRQ, d);
    for (int i = 0; i < 5; i++) begin
      cmd(`SSC_OP_UNLOCK, 1'b1, 16'h0000, PW_X, 8'h04);
    end
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0040); // counted to zero
    rdchk(`SSC_OFF_IRQ, 16'h0004, 16'h0004); // lockout event
    cmd(`SSC_OP_UNLOCK, 1'b0, 16'h0000, PW_U, 8'h04); // right password refused
    cmd(`SSC_OP_ERASE, 1'b0, 16'h0000, PW_U, 8'h04); // erase refused
    hwrst();
    rdchk(`SSC_OFF_SEC, 16'h0047, 16'h0045); // reset restores tries
    cmd(`SSC_OP_UNLOCK, 1'b1, 16'h0000, PW_U, 8'h00); // unlock again
    $display("lockout done");
  endtask : t_lockout

  task automatic t_freeze();
    host.wr(`SSC_OFF_CNT, 16'h0003);
    cmd(`SSC_OP_FREEZE, 1'b0, 16'h0, 256'h0, 8'h00); // freeze done
    rdchk(`SSC_OFF_SEC, 16'h0008, 16'h0008); // frozen
    rdchk(`SSC_OFF_CNT, 16'hffff, 16'h0000); // count cleared
    cmd(`SSC_OP_SETPW, 1'b0, 16'h0, PW_U, 8'h04); // set refused
    cmd(`SSC_OP_UNLOCK, 1'b0, 16'h0, PW_U, 8'h04); // unlock refused
    hwrst();
    rdchk(`SSC_OFF_SEC, 16'h0008, 16'h0000); // reset unfreezes
    $display("freeze done");
  endtask : t_freeze

  task automatic t_irq();
    logic [15:0] d;
    host.wr(`SSC_OFF_MASK, 16'h0000);
    host.rd(`SSC_OFF_IRQ, d);
    cmd(8'h70, 1'b0, 16'h0, 256'h0, 8'h00); // done while masked
    `SSC_CHK(irq_q, 1'b0)
    host.wr(`SSC_OFF_MASK, 16'h0001);
    rdchk(`SSC_OFF_MASK, 16'hffff, 16'h0001);
    `SSC_CHK(irq_q, 1'b1)
    rdchk(`SSC_OFF_IRQ, 16'h0007, 16'h0001);
    @(posedge clk_sys);
    @(posedge clk_sys);
    `SSC_CHK(irq_q, 1'b0)
    // clock enable low: the mask write must be ignored
    ce <= 1'b0;
    host.wr(`SSC_OFF_MASK, 16'h0006);
    ce <= 1'b1;
    rdchk(`SSC_OFF_MASK, 16'hffff, 16'h0001);
    `SSC_CHK(irq_q, 1'b0)
    $display("interrupt done");
  endtask : t_irq

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys  = 1'b0;
    nrst     = 1'b0;
    ce       = 1'b1;
    hw_reset = 1'b0;
    errors   = 0;
    compares = 0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_seek();
    t_user_high();
    t_user_max();
    t_lockout();
    t_freeze();
    t_irq();
    close_out();
  end
endmodule : tb_top
